// ==== verilog/fsrb_fault_status_bank.sv ====
// fault and status register bank: latched fault bytes, live status bytes
//
// Contract
// - soc reset output check latches bit 3, w1c
// - enable drive check latches bit 0, w1c
// - monitor reset event latches bit 5, w1c
// - monitor fail event latches bit 4, w1c
// - monitor pin fault latches bit 3, w1c
// - both latched registers reset to zero
// - converter one limits in low nibble
// - converter two limits in high nibble
// - converter three limits in low nibble
// - converter four limits in high nibble
// - analog supply low and high flags
// - monitor one low and high flags
// - monitor two low and high flags
// - startup register shows enable pin, bit 1
// - miscellaneous status register resets to zero
// - readback summary follows pending readback bits
// - monitor summary follows pending monitor bits
`timescale 1ns/1ps
module fsrb_fault_status_bank (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [fsrb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [fsrb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [fsrb_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire fsrb_pkg::fsrb_evt_t fault_evt,
  input wire fsrb_pkg::fsrb_conv_t [3:0] conv_status,
  input wire fsrb_pkg::fsrb_vmon_t vmon_status,
  input wire logic enable_pin,
  input wire logic thermal_warn,
  input wire logic ext_clk_invalid,
  output logic readback_summary_flag,
  output logic error_monitor_summary_flag
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hit(
    input logic [7:0] a,
    input logic [7:0] target
  );
    hit = (a == target);
  endfunction

  function automatic logic [7:0] conv_byte(
    input fsrb_pkg::fsrb_conv_t lo,
    input fsrb_pkg::fsrb_conv_t hi
  );
    logic [7:0] r;
    r = 8'h00;
    r[fsrb_pkg::CV_ILIM_BIT] = lo.current_limit;
    r[fsrb_pkg::CV_UV_BIT] = lo.undervoltage;
    r[fsrb_pkg::CV_OV_BIT] = lo.overvoltage;
    r[fsrb_pkg::CV_HI_SHIFT + fsrb_pkg::CV_ILIM_BIT] = hi.current_limit;
    r[fsrb_pkg::CV_HI_SHIFT + fsrb_pkg::CV_UV_BIT] = hi.undervoltage;
    r[fsrb_pkg::CV_HI_SHIFT + fsrb_pkg::CV_OV_BIT] = hi.overvoltage;
    conv_byte = r;
  endfunction

  // ----------------------------------------
  // event and status packing
  // ----------------------------------------
  logic [7:0] rb_set;
  logic [7:0] em_set;
  logic [7:0] conv12_d;
  logic [7:0] conv34_d;
  logic [7:0] vmon_d;
  logic [7:0] startup_d;
  logic [7:0] misc_d;

  always_comb begin
    rb_set = 8'h00;
    em_set = 8'h00;
    rb_set[fsrb_pkg::RB_SOC_BIT] = fault_evt.soc_reset_out_check_flag;
    rb_set[fsrb_pkg::RB_DRV_BIT] = fault_evt.ext_enable_drive_check_flag;
    em_set[fsrb_pkg::EM_RST_BIT] = fault_evt.mcu_monitor_reset_flag;
    em_set[fsrb_pkg::EM_FAIL_BIT] = fault_evt.mcu_monitor_fail_flag;
    em_set[fsrb_pkg::EM_PIN_BIT] = fault_evt.mcu_monitor_pin_fault_flag;
  end

  always_comb begin
    conv12_d = conv_byte(conv_status[0], conv_status[1]);
    conv34_d = conv_byte(conv_status[2], conv_status[3]);
    vmon_d = 8'h00;
    vmon_d[fsrb_pkg::VM_ANA_UV_BIT] = vmon_status.analog_supply_low_flag;
    vmon_d[fsrb_pkg::VM_ANA_OV_BIT] = vmon_status.analog_supply_high_flag;
    vmon_d[fsrb_pkg::VM_MON1_UV_BIT] = vmon_status.monitor_one_low_flag;
    vmon_d[fsrb_pkg::VM_MON1_OV_BIT] = vmon_status.monitor_one_high_flag;
    vmon_d[fsrb_pkg::VM_MON2_UV_BIT] = vmon_status.monitor_two_low_flag;
    vmon_d[fsrb_pkg::VM_MON2_OV_BIT] = vmon_status.monitor_two_high_flag;
    startup_d = 8'h00;
    startup_d[fsrb_pkg::SU_ENABLE_BIT] = enable_pin;
    misc_d = 8'h00;
    misc_d[fsrb_pkg::MS_TWARN_BIT] = thermal_warn;
    misc_d[fsrb_pkg::MS_EXTCLK_BIT] = ext_clk_invalid;
  end

  // ----------------------------------------
  // latched fault registers
  // ----------------------------------------
  logic rb_wr;
  logic em_wr;
  logic [7:0] rb_q;
  logic [7:0] em_q;

  assign rb_wr = reg_wr && hit(reg_addr, fsrb_pkg::ADDR_READBACK);
  assign em_wr = reg_wr && hit(reg_addr, fsrb_pkg::ADDR_ERRMON);

  // reserved bits of these two bytes are plain read/write storage
  fsrb_w1c_reg #(
    .W1C_MASK(fsrb_pkg::RB_W1C_MASK),
    .RESET_VAL(fsrb_pkg::REG_RESET)
  ) u_readback (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(rb_wr),
    .wdata(reg_wdata),
    .set_evt(rb_set),
    .q(rb_q)
  );

  fsrb_w1c_reg #(
    .W1C_MASK(fsrb_pkg::EM_W1C_MASK),
    .RESET_VAL(fsrb_pkg::REG_RESET)
  ) u_errmon (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(em_wr),
    .wdata(reg_wdata),
    .set_evt(em_set),
    .q(em_q)
  );

  // ----------------------------------------
  // live status registers
  // ----------------------------------------
  logic [7:0] conv12_q;
  logic [7:0] conv34_q;
  logic [7:0] vmon_q;
  logic [7:0] startup_q;
  logic [7:0] misc_q;
  logic [39:0] live_d;
  logic [39:0] live_q;

  assign live_d = {misc_d, startup_d, vmon_d, conv34_d, conv12_d};
  assign conv12_q = live_q[7:0];
  assign conv34_q = live_q[15:8];
  assign vmon_q = live_q[23:16];
  assign startup_q = live_q[31:24];
  assign misc_q = live_q[39:32];

  // one sample stage per byte; writes have no path
  for (genvar g = 0; g < 5; g++) begin : g_live
    fsrb_live_reg #(
      .KEEP_MASK(8'hff),
      .RESET_VAL(fsrb_pkg::REG_RESET)
    ) u_live (
      .clk(clk),
      .reset_n(reset_n),
      .d(live_d[g*8 +: 8]),
      .q(live_q[g*8 +: 8])
    );
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;
  logic rvalid_ff;

  always_comb begin
    if (hit(reg_addr, fsrb_pkg::ADDR_READBACK)) begin
      nxt_rdata = rb_q;
    end else if (hit(reg_addr, fsrb_pkg::ADDR_ERRMON)) begin
      nxt_rdata = em_q;
    end else if (hit(reg_addr, fsrb_pkg::ADDR_CONV12)) begin
      nxt_rdata = conv12_q;
    end else if (hit(reg_addr, fsrb_pkg::ADDR_CONV34)) begin
      nxt_rdata = conv34_q;
    end else if (hit(reg_addr, fsrb_pkg::ADDR_VMON)) begin
      nxt_rdata = vmon_q;
    end else if (hit(reg_addr, fsrb_pkg::ADDR_STARTUP)) begin
      nxt_rdata = startup_q;
    end else if (hit(reg_addr, fsrb_pkg::ADDR_MISC)) begin
      nxt_rdata = misc_q;
    end else begin
      nxt_rdata = fsrb_pkg::UNMAPPED_DATA;
    end
  end

  // data holds between reads so slow serial front ends can pick it up
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_ff <= fsrb_pkg::REG_RESET;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rdata_valid = rvalid_ff;

  // ----------------------------------------
  // summary flags
  // ----------------------------------------
  logic rb_sum_ff;
  logic em_sum_ff;

  // any pending bit counts, reserved storage bits included
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rb_sum_ff <= 1'b0;
    end else begin
      rb_sum_ff <= |rb_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      em_sum_ff <= 1'b0;
    end else begin
      em_sum_ff <= |em_q;
    end
  end

  assign readback_summary_flag = rb_sum_ff;
  assign error_monitor_summary_flag = em_sum_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_soc_check_latch: assert property (
    fault_evt.soc_reset_out_check_flag |=> rb_q[fsrb_pkg::RB_SOC_BIT]
  ) else $error("soc reset check event not latched");

  a_soc_check_clear: assert property (
    rb_wr && reg_wdata[fsrb_pkg::RB_SOC_BIT] && !fault_evt.soc_reset_out_check_flag
    |=> !rb_q[fsrb_pkg::RB_SOC_BIT]
  ) else $error("soc reset check bit not cleared by write of one");

  a_drv_check_hold: assert property (
    rb_q[fsrb_pkg::RB_DRV_BIT] && !(rb_wr && reg_wdata[fsrb_pkg::RB_DRV_BIT])
    |=> rb_q[fsrb_pkg::RB_DRV_BIT]
  ) else $error("enable drive check bit lost without clear");

  a_drv_check_latch: assert property (
    fault_evt.ext_enable_drive_check_flag |=> rb_q[fsrb_pkg::RB_DRV_BIT]
  ) else $error("enable drive check event not latched");

  a_drv_check_clear: assert property (
    rb_wr && reg_wdata[fsrb_pkg::RB_DRV_BIT] && !fault_evt.ext_enable_drive_check_flag
    |=> !rb_q[fsrb_pkg::RB_DRV_BIT]
  ) else $error("enable drive check bit not cleared by write of one");

  a_mon_reset_latch: assert property (
    fault_evt.mcu_monitor_reset_flag |=> em_q[fsrb_pkg::EM_RST_BIT]
  ) else $error("monitor reset event not latched");

  a_mon_fail_cycle: assert property (
    $rose(em_q[fsrb_pkg::EM_FAIL_BIT]) |-> $past(fault_evt.mcu_monitor_fail_flag)
  ) else $error("monitor fail bit rose without event");

  a_mon_fail_clear: assert property (
    em_wr && reg_wdata[fsrb_pkg::EM_FAIL_BIT] && !fault_evt.mcu_monitor_fail_flag
    |=> !em_q[fsrb_pkg::EM_FAIL_BIT]
  ) else $error("monitor fail bit not cleared by write of one");

  a_mon_pin_clear: assert property (
    em_q[fsrb_pkg::EM_PIN_BIT] && em_wr && reg_wdata[fsrb_pkg::EM_PIN_BIT]
    && !fault_evt.mcu_monitor_pin_fault_flag
    |=> !em_q[fsrb_pkg::EM_PIN_BIT]
  ) else $error("monitor pin fault bit not cleared");

  a_latch_reset_zero: assert property (
    disable iff (1'b0)
    !reset_n |=> (rb_q == fsrb_pkg::REG_RESET) && (em_q == fsrb_pkg::REG_RESET)
    && (misc_q == fsrb_pkg::REG_RESET)
  ) else $error("registers not zero after reset");

  a_conv12_read: assert property (
    reg_rd && hit(reg_addr, fsrb_pkg::ADDR_CONV12) && $past(reset_n)
    |=> reg_rdata_valid && reg_rdata == conv_byte($past(conv_status[0], 2), $past(conv_status[1], 2))
  ) else $error("converter one/two status read wrong");

  a_conv34_read: assert property (
    reg_rd && hit(reg_addr, fsrb_pkg::ADDR_CONV34) && $past(reset_n)
    |=> reg_rdata == conv_byte($past(conv_status[2], 2), $past(conv_status[3], 2))
  ) else $error("converter three/four status read wrong");

  a_vmon_read: assert property (
    reg_rd && hit(reg_addr, fsrb_pkg::ADDR_VMON) && $past(reset_n)
    |=> reg_rdata == {1'b0, $past(vmon_status.monitor_two_low_flag, 2),
        $past(vmon_status.monitor_two_high_flag, 2), 1'b0,
        $past(vmon_status.monitor_one_low_flag, 2), $past(vmon_status.monitor_one_high_flag, 2),
        $past(vmon_status.analog_supply_low_flag, 2), $past(vmon_status.analog_supply_high_flag, 2)}
  ) else $error("voltage monitor status read wrong");

  a_startup_read: assert property (
    reg_rd && hit(reg_addr, fsrb_pkg::ADDR_STARTUP) && $past(reset_n)
    |=> reg_rdata == {6'h00, $past(enable_pin, 2), 1'b0}
  ) else $error("startup status read wrong");

  a_rb_summary_track: assert property (
    ##1 readback_summary_flag == (|$past(rb_q))
  ) else $error("readback summary out of step");

  a_em_summary_clear: assert property (
    (em_q == fsrb_pkg::REG_RESET) [*2] |-> !error_monitor_summary_flag
  ) else $error("monitor summary stuck after clear");

  a_live_ignore_write: assert property (
    reg_wr && hit(reg_addr, fsrb_pkg::ADDR_CONV12) ##1 reg_rd && hit(reg_addr, fsrb_pkg::ADDR_CONV12)
    |=> reg_rdata == conv_byte($past(conv_status[0], 2), $past(conv_status[1], 2))
  ) else $error("write disturbed live status");

  c_latch_then_clear: cover property (
    fault_evt.soc_reset_out_check_flag ##1 rb_q[fsrb_pkg::RB_SOC_BIT] ##[1:20] !rb_q[fsrb_pkg::RB_SOC_BIT]
  );

  c_em_summary_cycle: cover property (
    $rose(error_monitor_summary_flag) ##[1:40] $fell(error_monitor_summary_flag)
  );

  c_set_meets_clear: cover property (
    rb_wr && reg_wdata[fsrb_pkg::RB_SOC_BIT] && fault_evt.soc_reset_out_check_flag
  );

  c_vmon_read: cover property (
    reg_rd && hit(reg_addr, fsrb_pkg::ADDR_VMON) ##1 reg_rdata != fsrb_pkg::REG_RESET
  );

endmodule

// ==== verilog/fsrb_pkg.sv ====
// shared constants and carrier types for the fault and status register bank
package fsrb_pkg;

  // ----------------------------------------
  // register port geometry
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // register offsets and reset value
  // ----------------------------------------
  localparam logic [7:0] ADDR_READBACK = 8'h6b;
  localparam logic [7:0] ADDR_ERRMON = 8'h6c;
  localparam logic [7:0] ADDR_CONV12 = 8'h6d;
  localparam logic [7:0] ADDR_CONV34 = 8'h6e;
  localparam logic [7:0] ADDR_VMON = 8'h72;
  localparam logic [7:0] ADDR_STARTUP = 8'h73;
  localparam logic [7:0] ADDR_MISC = 8'h74;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ----------------------------------------
  // latched register fields
  // ----------------------------------------
  localparam int RB_SOC_BIT = 3;
  localparam int RB_DRV_BIT = 0;
  localparam logic [7:0] RB_W1C_MASK = 8'h09;
  localparam int EM_RST_BIT = 5;
  localparam int EM_FAIL_BIT = 4;
  localparam int EM_PIN_BIT = 3;
  localparam logic [7:0] EM_W1C_MASK = 8'h38;

  // ----------------------------------------
  // live status fields
  // ----------------------------------------
  localparam int CV_ILIM_BIT = 3;
  localparam int CV_UV_BIT = 1;
  localparam int CV_OV_BIT = 0;
  localparam int CV_HI_SHIFT = 4;
  localparam int VM_ANA_UV_BIT = 1;
  localparam int VM_ANA_OV_BIT = 0;
  localparam int VM_MON1_UV_BIT = 3;
  localparam int VM_MON1_OV_BIT = 2;
  localparam int VM_MON2_UV_BIT = 6;
  localparam int VM_MON2_OV_BIT = 5;
  localparam int SU_ENABLE_BIT = 1;
  localparam int MS_TWARN_BIT = 3;
  localparam int MS_EXTCLK_BIT = 1;

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic soc_reset_out_check_flag;
    logic ext_enable_drive_check_flag;
    logic mcu_monitor_reset_flag;
    logic mcu_monitor_fail_flag;
    logic mcu_monitor_pin_fault_flag;
  } fsrb_evt_t;

  typedef struct packed {
    logic current_limit;
    logic undervoltage;
    logic overvoltage;
  } fsrb_conv_t;

  typedef struct packed {
    logic analog_supply_low_flag;
    logic analog_supply_high_flag;
    logic monitor_one_low_flag;
    logic monitor_one_high_flag;
    logic monitor_two_low_flag;
    logic monitor_two_high_flag;
  } fsrb_vmon_t;

endpackage

// ==== verilog/fsrb_w1c_reg.sv ====
// byte register mixing write-one-to-clear event bits with plain storage bits
`timescale 1ns/1ps
module fsrb_w1c_reg #(
  parameter logic [7:0] W1C_MASK = 8'h00,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] set_evt,
  output logic [7:0] q
);

  logic [7:0] q_ff;
  logic [7:0] nxt_q;

  // set wins over a same-cycle clear so no event is lost
  always_comb begin
    nxt_q = q_ff;
    if (wr_en) begin
      nxt_q = (q_ff & W1C_MASK & ~wdata) | (wdata & ~W1C_MASK);
    end
    nxt_q = nxt_q | (set_evt & W1C_MASK);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_ff <= RESET_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule

// ==== verilog/fsrb_live_reg.sv ====
// sampled live status byte; bits outside KEEP_MASK forced to zero
`timescale 1ns/1ps
module fsrb_live_reg #(
  parameter logic [7:0] KEEP_MASK = 8'hff,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] d,
  output logic [7:0] q
);

  logic [7:0] q_ff;

  // writes never reach this register, it only follows its inputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_ff <= RESET_VAL;
    end else begin
      q_ff <= d & KEEP_MASK;
    end
  end

  assign q = q_ff;

endmodule

// ==== bench/fault_status_register_bank_test.sv ====
// self-checking bench for the fault and status register bank
`timescale 1ns/1ps
module fault_status_register_bank_test;

  // ----------------------------------------
  // stimulus and observation signals
  // ----------------------------------------
  typedef struct packed {
    logic [11:0] conv;
    logic [5:0] vm;
    logic [2:0] pins;
    logic [39:0] exp;
  } fsrb_live_row_t;

  logic clk;
  logic reset_n;
  logic [fsrb_pkg::ADDR_W-1:0] reg_addr;
  logic reg_wr;
  logic [fsrb_pkg::DATA_W-1:0] reg_wdata;
  logic reg_rd;
  logic [fsrb_pkg::DATA_W-1:0] reg_rdata;
  logic reg_rdata_valid;
  fsrb_pkg::fsrb_evt_t fault_evt;
  fsrb_pkg::fsrb_conv_t [3:0] conv_status;
  fsrb_pkg::fsrb_vmon_t vmon_status;
  logic enable_pin;
  logic thermal_warn;
  logic ext_clk_invalid;
  logic readback_summary_flag;
  logic error_monitor_summary_flag;
  int bad_count;
  int tests_run;
  fsrb_live_row_t rows [8];
  logic [7:0] live_addr [5];
  logic [4:0] evt_bit [5];
  logic [7:0] evt_addr [5];
  logic [7:0] evt_mask [5];

  fsrb_fault_status_bank u_fsrb_fault_status_bank (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid),
    .fault_evt(fault_evt),
    .conv_status(conv_status),
    .vmon_status(vmon_status),
    .enable_pin(enable_pin),
    .thermal_warn(thermal_warn),
    .ext_clk_invalid(ext_clk_invalid),
    .readback_summary_flag(readback_summary_flag),
    .error_monitor_summary_flag(error_monitor_summary_flag)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // strobe lowered with an edge to spare so the next access never re-drives it in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    chk({7'h00, reg_rdata_valid}, 8'h01, "read valid");
    chk(reg_rdata, exp, "read data");
    reg_rd = 1'b0;
    tick();
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_all_zero();
    for (int j = 0; j < 5; j++) begin
      rd_chk(live_addr[j], 8'h00);
    end
    rd_chk(fsrb_pkg::ADDR_READBACK, 8'h00);
    rd_chk(fsrb_pkg::ADDR_ERRMON, 8'h00);
    chk({6'h00, readback_summary_flag, error_monitor_summary_flag}, 8'h00, "summary after reset");
  endtask

  // ----------------------------------------
  // watchdog: whole sequence needs well under 1000 cycles
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    bad_count = 0;
    tests_run = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    fault_evt = '0;
    conv_status = '0;
    vmon_status = '0;
    enable_pin = 1'b0;
    thermal_warn = 1'b0;
    ext_clk_invalid = 1'b0;
    live_addr = '{fsrb_pkg::ADDR_CONV12, fsrb_pkg::ADDR_CONV34, fsrb_pkg::ADDR_VMON,
                  fsrb_pkg::ADDR_STARTUP, fsrb_pkg::ADDR_MISC};
    // expected bytes in order 0x6d, 0x6e, 0x72, 0x73, 0x74
    rows = '{'{12'h000, 6'h00, 3'b000, 40'h00_00_00_00_00},
             '{12'h004, 6'h20, 3'b000, 40'h08_00_02_00_00},
             '{12'h00a, 6'h10, 3'b000, 40'h12_00_01_00_00},
             '{12'h2a0, 6'h08, 3'b000, 40'h80_12_08_00_00},
             '{12'hd00, 6'h04, 3'b000, 40'h00_a8_04_00_00},
             '{12'ha07, 6'h02, 3'b000, 40'h0b_90_40_00_00},
             '{12'h000, 6'h01, 3'b110, 40'h00_00_20_02_08},
             '{12'h000, 6'h3f, 3'b001, 40'h00_00_6f_00_02}};
    evt_bit = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    evt_addr = '{8'h6b, 8'h6b, 8'h6c, 8'h6c, 8'h6c};
    evt_mask = '{8'h08, 8'h01, 8'h20, 8'h10, 8'h08};
    repeat (8) @(posedge clk);
    #1;
    reset_n = 1'b1;
    tick();
    check_all_zero();
    rd_chk(8'h70, fsrb_pkg::UNMAPPED_DATA);

    // live status rows; each register is written first, the write must not stick
    foreach (rows[i]) begin
      conv_status = rows[i].conv;
      vmon_status = rows[i].vm;
      {enable_pin, thermal_warn, ext_clk_invalid} = rows[i].pins;
      for (int j = 0; j < 5; j++) begin
        wr(live_addr[j], 8'hff);
        rd_chk(live_addr[j], rows[i].exp[39-8*j -: 8]);
      end
    end

    // each event latches, holds after the cause goes, and only a one clears it
    for (int k = 0; k < 5; k++) begin
      fault_evt = evt_bit[k];
      tick();
      fault_evt = '0;
      repeat (3) tick();
      wr(evt_addr[k], 8'h00);
      rd_chk(evt_addr[k], evt_mask[k]);
      chk({6'h00, readback_summary_flag, error_monitor_summary_flag},
          (k < 2) ? 8'h02 : 8'h01, "summary while pending");
      wr(evt_addr[k], evt_mask[k]);
      rd_chk(evt_addr[k], 8'h00);
      tick();
      chk({6'h00, readback_summary_flag, error_monitor_summary_flag}, 8'h00, "summary after clear");
    end

    // spare bits hold written data and raise the summary; clear-on-one bits cannot be set by a write
    wr(fsrb_pkg::ADDR_READBACK, 8'hff);
    wr(fsrb_pkg::ADDR_ERRMON, 8'hff);
    rd_chk(fsrb_pkg::ADDR_READBACK, 8'hf6);
    rd_chk(fsrb_pkg::ADDR_ERRMON, 8'hc7);
    chk({6'h00, readback_summary_flag, error_monitor_summary_flag}, 8'h03, "summary on spare bits");
    wr(fsrb_pkg::ADDR_READBACK, 8'h00);
    wr(fsrb_pkg::ADDR_ERRMON, 8'h00);
    tick();
    chk({6'h00, readback_summary_flag, error_monitor_summary_flag}, 8'h00, "summary spare cleared");

    // a new event in the clearing cycle must not be lost
    fault_evt = 5'h10;
    reg_addr = fsrb_pkg::ADDR_READBACK;
    reg_wdata = 8'h08;
    reg_wr = 1'b1;
    tick();
    fault_evt = '0;
    reg_wr = 1'b0;
    tick();
    rd_chk(fsrb_pkg::ADDR_READBACK, 8'h08);

    // a read in the clearing cycle returns the old byte, which then stands while valid drops
    reg_addr = fsrb_pkg::ADDR_READBACK;
    reg_wdata = 8'h08;
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    tick();
    chk(reg_rdata, 8'h08, "read beside clear");
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tick();
    chk({reg_rdata_valid, reg_rdata[6:0]}, 8'h08, "valid drops, data stands");
    rd_chk(fsrb_pkg::ADDR_READBACK, 8'h00);

    // a second reset in mid-run drops pending latches and spare storage
    fault_evt = 5'h03;
    tick();
    fault_evt = '0;
    wr(fsrb_pkg::ADDR_ERRMON, 8'h80);
    conv_status = '0;
    vmon_status = '0;
    {enable_pin, thermal_warn, ext_clk_invalid} = 3'b000;
    reset_n = 1'b0;
    repeat (2) tick();
    reset_n = 1'b1;
    tick();
    check_all_zero();
    print_verdict();
  end

endmodule
